// *** common/io_cell_pkg.sv ***
// Purpose: shared constants for the pin cell capture, tri-state and gearbox logic
// Assumes: APB register slave with 32-bit data, one word per register
// Notes: offsets are byte addresses

package io_cell_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] DATA_OFFSET = 8'h08;

  // control fields
  localparam int unsigned CTRL_DDR_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_GEAR_RST_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;

  // status fields
  localparam int unsigned STAT_EMPTY_BIT = 0;
  localparam int unsigned STAT_FULL_BIT = 1;
  localparam int unsigned STAT_OVERRUN_BIT = 2;
  localparam int unsigned STAT_RISE_BIT = 3;
  localparam int unsigned STAT_FALL_BIT = 4;
  localparam int unsigned STAT_OE_N_BIT = 5;
  localparam int unsigned STAT_SLIP_BIT = 6;

  // ----------------------------------------------------------------
  // gearbox
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GEAR_SEVEN = 2'b00,
    GEAR_EIGHT = 2'b01,
    GEAR_DUAL_FOUR = 2'b10
  } gear_mode_t;

  localparam logic [3:0] LEN_SEVEN = 4'h7;
  localparam logic [3:0] LEN_EIGHT = 4'h8;
  localparam logic [3:0] LEN_FOUR = 4'h4;
  localparam int unsigned WORD_W = 8;
  localparam int unsigned FIFO_DEPTH = 4;

  // this cell sits on the right edge, so the ddr memory path exists
  localparam logic EDGE_IS_RIGHT = 1'b1;

endpackage : io_cell_pkg

// *** logic/io_cell_ddr_capture_gearbox.sv ***
// Purpose: pin cell logic: ddr strobe capture, registered tri-state, input gearbox
// Assumes: strobes, edge clock and pins are asynchronous and slow against pclk
// Notes: all edges are found by sampling on pclk; apb slave answers with no wait

`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// small word buffer
// ------------------------------------------------------------------
module word_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  // the count is one bit wider than the pointers so that full and empty differ
  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // word_fifo

// ------------------------------------------------------------------
// one deserializer lane
// ------------------------------------------------------------------
module deser_lane #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic bit_en,
  input wire logic bit_in,
  input wire logic slip,
  input wire logic [3:0] len,
  output logic [W-1:0] word_q,
  output logic done_q,
  output logic slip_pend_q
);
  logic [W-1:0] sh_q;
  logic [3:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= '0;
      cnt_q <= '0;
      word_q <= '0;
      done_q <= 1'b0;
      slip_pend_q <= 1'b0;
    end else if (clear) begin
      sh_q <= '0;
      cnt_q <= '0;
      done_q <= 1'b0;
      slip_pend_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (bit_en) begin
        sh_q <= {sh_q[W-2:0], bit_in};
        if (slip_pend_q) begin
          // the skipped count moves the boundary by one bit
          slip_pend_q <= 1'b0;
        end else if (cnt_q == len - 4'h1) begin
          cnt_q <= '0;
          word_q <= {sh_q[W-2:0], bit_in};
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
      if (slip) begin
        slip_pend_q <= 1'b1;
      end
    end
  end
endmodule // deser_lane

module io_cell_ddr_capture_gearbox
  import io_cell_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pad_data_in,
  input wire logic [1:0] delayed_data_in,
  input wire logic shifted_read_strobe,
  input wire logic shifted_write_strobe,
  input wire logic fast_edge_clock,
  input wire logic sync_clock_polarity,
  input wire logic single_rate_tristate_in,
  input wire logic ddr_tristate_in,
  input wire logic word_align_request,
  output logic ddr_rise_q,
  output logic ddr_fall_q,
  output logic buffer_oe_n,
  output logic [7:0] gear_word_q,
  output logic gear_word_valid_q,
  output logic gear_word_ready
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_s1_q, pin_s2_q;
  logic [2:0] edge_s3_q;
  logic pad_s, rstb_s, wstb_s, eclk_s;
  logic [1:0] ddat_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      edge_s3_q <= '0;
    end else begin
      pin_s1_q <= {delayed_data_in, fast_edge_clock, shifted_write_strobe,
                   shifted_read_strobe, pad_data_in};
      pin_s2_q <= pin_s1_q;
      edge_s3_q <= pin_s2_q[3:1];
    end
  end

  assign pad_s = pin_s2_q[0];
  assign rstb_s = pin_s2_q[1];
  assign wstb_s = pin_s2_q[2];
  assign eclk_s = pin_s2_q[3];
  assign ddat_s = pin_s2_q[5:4];

  logic rstb_rise, rstb_fall, wstb_rise, eclk_edge;
  assign rstb_rise = rstb_s && !edge_s3_q[0];
  assign rstb_fall = !rstb_s && edge_s3_q[0];
  assign wstb_rise = wstb_s && !edge_s3_q[1];
  assign eclk_edge = eclk_s ^ edge_s3_q[2];

  // ----------------------------------------------------------------
  // control register and mode decode
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic ddr_mode, gear_rst;
  gear_mode_t gear_mode;

  assign ddr_mode = ctrl_q[CTRL_DDR_EN_BIT] && EDGE_IS_RIGHT;
  assign gear_rst = ctrl_q[CTRL_GEAR_RST_BIT];
  assign gear_mode = gear_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);

  // ----------------------------------------------------------------
  // ddr capture and system-clock resync
  // ----------------------------------------------------------------
  logic rise_cap_q, fall_cap_q, rise_hold_q, fall_hold_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_cap_q <= 1'b0;
      fall_cap_q <= 1'b0;
    end else if (ddr_mode) begin
      if (rstb_rise) begin
        rise_cap_q <= pad_s;
      end
      if (rstb_fall) begin
        fall_cap_q <= pad_s;
      end
    end
  end

  // the inverted-clock choice is modelled as one extra stage of margin,
  // since a single clock cannot offer a true half-cycle sample point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_hold_q <= 1'b0;
      fall_hold_q <= 1'b0;
      ddr_rise_q <= 1'b0;
      ddr_fall_q <= 1'b0;
    end else begin
      rise_hold_q <= rise_cap_q;
      fall_hold_q <= fall_cap_q;
      ddr_rise_q <= sync_clock_polarity ? rise_hold_q : rise_cap_q;
      ddr_fall_q <= sync_clock_polarity ? fall_hold_q : fall_cap_q;
    end
  end

  // ----------------------------------------------------------------
  // tri-state registers (low enable drives the pin)
  // ----------------------------------------------------------------
  logic ts_sdr_q, ts_ddr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_sdr_q <= 1'b1;
      ts_ddr_q <= 1'b1;
    end else begin
      ts_sdr_q <= single_rate_tristate_in;
      if (wstb_rise) begin
        ts_ddr_q <= ddr_tristate_in;
      end
    end
  end

  assign buffer_oe_n = ddr_mode ? ts_ddr_q : ts_sdr_q;

  // ----------------------------------------------------------------
  // input gearbox
  // ----------------------------------------------------------------
  logic [3:0] len_a;
  logic [7:0] word_a;
  logic [3:0] word_c;
  logic done_a, done_c, slip_a, slip_c;

  always_comb begin
    case (gear_mode)
      GEAR_SEVEN: len_a = LEN_SEVEN;
      GEAR_EIGHT: len_a = LEN_EIGHT;
      GEAR_DUAL_FOUR: len_a = LEN_FOUR;
      default: len_a = LEN_EIGHT;
    endcase
  end

  deser_lane #(.W(8)) lane_first (
    .clk(pclk),
    .rst_n(presetn),
    .clear(gear_rst),
    .bit_en(eclk_edge),
    .bit_in(ddat_s[0]),
    .slip(word_align_request),
    .len(len_a),
    .word_q(word_a),
    .done_q(done_a),
    .slip_pend_q(slip_a)
  );

  deser_lane #(.W(4)) lane_third (
    .clk(pclk),
    .rst_n(presetn),
    .clear(gear_rst || gear_mode != GEAR_DUAL_FOUR),
    .bit_en(eclk_edge),
    .bit_in(ddat_s[1]),
    .slip(word_align_request),
    .len(LEN_FOUR),
    .word_q(word_c),
    .done_q(done_c),
    .slip_pend_q(slip_c)
  );

  logic c_live;
  assign c_live = done_c && gear_mode == GEAR_DUAL_FOUR;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gear_word_q <= '0;
      gear_word_valid_q <= 1'b0;
    end else if (gear_rst) begin
      gear_word_q <= '0;
      gear_word_valid_q <= 1'b0;
    end else begin
      gear_word_valid_q <= done_a || c_live;
      if (done_a) begin
        case (gear_mode)
          GEAR_SEVEN: gear_word_q <= {1'b0, word_a[6:0]};
          GEAR_EIGHT: gear_word_q <= word_a;
          default: gear_word_q[7:4] <= word_a[3:0];
        endcase
      end
      if (c_live) begin
        gear_word_q[3:0] <= word_c;
      end
    end
  end

  // ----------------------------------------------------------------
  // word buffer and apb slave
  // ----------------------------------------------------------------
  logic fifo_valid, fifo_pop, overrun_q, wr_en, rd_acc;
  logic [7:0] fifo_data;
  logic [31:0] status;

  assign wr_en = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign fifo_pop = rd_acc && paddr == DATA_OFFSET;

  word_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) buffer (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(gear_word_valid_q),
    .in_ready(gear_word_ready),
    .in_data(gear_word_q),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_en && paddr == CTRL_OFFSET) begin
      ctrl_q <= pwdata & 32'h0000_000f;
    end
  end

  // a word lost to a full buffer sets this; set beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_q <= 1'b0;
    end else if (gear_word_valid_q && !gear_word_ready) begin
      overrun_q <= 1'b1;
    end else if (wr_en && paddr == STATUS_OFFSET && pwdata[STAT_OVERRUN_BIT]) begin
      overrun_q <= 1'b0;
    end
  end

  always_comb begin
    status = '0;
    status[STAT_EMPTY_BIT] = !fifo_valid;
    status[STAT_FULL_BIT] = !gear_word_ready;
    status[STAT_OVERRUN_BIT] = overrun_q;
    status[STAT_RISE_BIT] = ddr_rise_q;
    status[STAT_FALL_BIT] = ddr_fall_q;
    status[STAT_OE_N_BIT] = buffer_oe_n;
    status[STAT_SLIP_BIT] = slip_a || slip_c;
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != CTRL_OFFSET && paddr != STATUS_OFFSET
                   && !(paddr == DATA_OFFSET && !pwrite);

  always_comb begin
    case (paddr)
      CTRL_OFFSET: prdata = ctrl_q;
      STATUS_OFFSET: prdata = status;
      DATA_OFFSET: prdata = {24'h00_0000, fifo_valid ? fifo_data : 8'h00};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rise_capture_a: assert property (ddr_mode && rstb_rise |=> rise_cap_q == $past(pad_s))
    else $error("rise capture missed pin data");
  fall_capture_a: assert property (ddr_mode && rstb_fall |=> fall_cap_q == $past(pad_s))
    else $error("fall capture missed pin data");
  sync_true_a: assert property (!sync_clock_polarity |=> ddr_rise_q == $past(rise_cap_q))
    else $error("true polarity resync wrong");
  sync_inv_a: assert property (sync_clock_polarity |=> ddr_fall_q == $past(fall_cap_q, 2))
    else $error("inverted polarity resync wrong");
  oe_sdr_a: assert property (!ddr_mode && $past(!ddr_mode)
                             |-> buffer_oe_n == $past(single_rate_tristate_in))
    else $error("single rate enable not registered");
  oe_ddr_a: assert property (ddr_mode && wstb_rise ##1 ddr_mode
                             |-> buffer_oe_n == $past(ddr_tristate_in))
    else $error("ddr enable not taken on write strobe");
  seven_bit_a: assert property (gear_mode == GEAR_SEVEN && gear_word_valid_q
                                && $past(!gear_rst) |-> !gear_word_q[7])
    else $error("bit 7 set in 1:7 mode");
  slip_skip_a: assert property (slip_a && eclk_edge && !word_align_request
                                && !gear_rst |=> !slip_a && !done_a)
    else $error("alignment slip not consumed");
  gear_reset_a: assert property (gear_rst |=> !gear_word_valid_q && !slip_a ##1 !done_a)
    else $error("gearbox reset left state");
  full_block_a: assert property (gear_word_valid_q && !gear_word_ready |=> overrun_q)
    else $error("word lost to full buffer not flagged");

  word_out_c: cover property (gear_word_valid_q && gear_word_ready);
  dual_c: cover property (c_live && done_a);
  ddr_c: cover property (ddr_mode && rstb_rise ##[1:20] rstb_fall);
  overrun_c: cover property (gear_word_valid_q && !gear_word_ready);

endmodule // io_cell_ddr_capture_gearbox

`default_nettype wire

// *** test/link_source.sv ***
// Purpose: far-side serial source for the input gearbox lanes
// Assumes: one edge-clock edge every 40 ns, each edge carries one bit per lane
// Notes: clock stands still between frames; released data shows the inverse

`timescale 1ns/10ps
`default_nettype none

module link_source (
  input wire logic start,
  input wire logic [8:0] bits0,
  input wire logic [8:0] bits1,
  input wire logic [3:0] nbits,
  output logic edge_clk,
  output logic [1:0] ser,
  output logic busy
);
  // one process owns every output, so idle levels and frames never fight
  // data leads and trails each edge by half a bit, so either sync skew is safe
  initial begin
    edge_clk = 1'b0;
    ser = 2'b01;
    busy = 1'b0;
    forever begin
      @(posedge start);
      busy = 1'b1;
      for (int i = int'(nbits) - 1; i >= 0; i--) begin
        ser = {bits1[i], bits0[i]};
        #20 edge_clk = ~edge_clk;
        #20;
      end
      ser = ~ser;
      busy = 1'b0;
    end
  end
endmodule // link_source

`default_nettype wire

// *** test/io_cell_ddr_capture_gearbox_tb.sv ***
// Purpose: self-checking bench for the pin cell capture, tri-state and gearbox
// Assumes: zero-wait apb slave; link source model on the gearbox serial side
// Notes: apb answers are taken at the rising edge that completes the access

`timescale 1ns/10ps
`default_nettype none

module io_cell_ddr_capture_gearbox_tb
  import io_cell_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pad = 1'b0, rstb = 1'b0, wstb = 1'b0, pol = 1'b0;
  logic sr_ts = 1'b1, ddr_ts = 1'b1, align = 1'b0, start = 1'b0, busy, eclk;
  logic rise, fall, oe_n, gv, gr;
  logic [7:0] gw, last_w = 8'h00;
  logic [1:0] dat;
  logic [8:0] b0 = 9'h0, b1 = 9'h0;
  logic [3:0] nb = 4'h0;
  int err_count = 0, checks = 0, nw = 0, cyc_n = 0;

  always #5 pclk = ~pclk;

  io_cell_ddr_capture_gearbox DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_data_in(pad), .delayed_data_in(dat),
    .shifted_read_strobe(rstb), .shifted_write_strobe(wstb), .fast_edge_clock(eclk),
    .sync_clock_polarity(pol), .single_rate_tristate_in(sr_ts), .ddr_tristate_in(ddr_ts),
    .word_align_request(align), .ddr_rise_q(rise), .ddr_fall_q(fall), .buffer_oe_n(oe_n),
    .gear_word_q(gw), .gear_word_valid_q(gv), .gear_word_ready(gr));

  link_source far (.start(start), .bits0(b0), .bits1(b1), .nbits(nb), .edge_clk(eclk),
    .ser(dat), .busy(busy));

  // word monitor: counts valid pulses and keeps the last word shown
  always @(posedge pclk) begin
    cyc_n <= cyc_n + 1;
    if (gv === 1'b1) begin
      last_w <= gw;
      nw <= nw + 1;
    end
    if (cyc_n == 8000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // a wait state keeps the whole request standing until pready is seen, for at most 50 cycles
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(e), 32'(xe));
    if (!w) chk(r & m, x);
  endtask

  task automatic ctl(input logic [31:0] v);
    acc(1'b1, CTRL_OFFSET, v, 32'h0, 32'h0, 1'b0);
  endtask

  // one serial frame; ck says whether a complete word must follow
  task automatic gear(input logic [8:0] x0, input logic [8:0] x1, input int n,
                      input logic ck, input logic [7:0] e);
    int t, n0;
    t = 0;
    n0 = nw;
    @(posedge pclk);
    b0 <= x0;
    b1 <= x1;
    nb <= 4'(n);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    while ((busy === 1'b1 || nw == n0) && t < 60) begin
      @(posedge pclk);
      t++;
    end
    chk(32'(nw != n0), 32'(ck));
    if (ck) chk(32'(last_w), 32'(e));
  endtask

  function automatic logic [7:0] expw(int m, logic [8:0] x0, logic [8:0] x1);
    case (m)
      0: return {1'b0, x0[6:0]};
      1: return x0[7:0];
      default: return {x0[3:0], x1[3:0]};
    endcase
  endfunction

  initial begin
    logic v, p, a;
    logic [8:0] x0, x1;
    logic [7:0] q[4];
    void'($urandom(32'h40178397));
    cyc(6);
    presetn <= 1'b1;
    acc(1'b0, CTRL_OFFSET, 0, 32'hffff_ffff, CTRL_RESET, 1'b0);
    acc(1'b0, STATUS_OFFSET, 0, 32'h7f, 32'h21, 1'b0);
    acc(1'b0, 8'h0c, 0, 32'hffff_ffff, 32'h0, 1'b1);
    acc(1'b1, DATA_OFFSET, 32'h5, 32'h0, 32'h0, 1'b1);
    p = 1'b1;
    for (int i = 0; i < 6; i++) begin
      v = 1'($urandom);
      @(posedge pclk);
      sr_ts <= v;
      ddr_ts <= ~v;
      @(negedge pclk);
      chk(32'(oe_n), 32'(p));
      @(negedge pclk);
      chk(32'(oe_n), 32'(v));
      p = v;
    end
    ctl(32'h9);
    for (int k = 0; k < 4; k++) begin
      a = 1'($urandom);
      pol <= k[0];
      pad <= a;
      cyc(4);
      rstb <= 1'b1;
      cyc(4);
      pad <= ~a;
      cyc(4);
      rstb <= 1'b0;
      cyc(10);
      chk(32'({rise, fall}), 32'({a, ~a}));
    end
    for (int k = 0; k < 2; k++) begin
      ddr_ts <= k[0];
      sr_ts <= ~k[0];
      cyc(4);
      wstb <= 1'b1;
      cyc(8);
      chk(32'(oe_n), 32'(k[0]));
      ddr_ts <= ~k[0];
      wstb <= 1'b0;
      cyc(8);
      chk(32'(oe_n), 32'(k[0]));
    end
    for (int m = 0; m < 3; m++) begin
      ctl(32'(m << 1) | 32'h8);
      ctl(32'(m << 1));
      x0 = 9'($urandom);
      x1 = 9'($urandom);
      gear(x0, x1, (m == 0) ? 7 : (m == 1) ? 8 : 4, 1'b1, expw(m, x0, x1));
      acc(1'b0, DATA_OFFSET, 0, 32'hff, 32'(expw(m, x0, x1)), 1'b0);
    end
    ctl(32'h0a);
    ctl(32'h02);
    gear(9'h1ff, 9'h0, 3, 1'b0, 8'h0);
    ctl(32'h0a);
    ctl(32'h02);
    x0 = 9'($urandom);
    gear(x0, 9'h0, 8, 1'b1, x0[7:0]);
    acc(1'b0, DATA_OFFSET, 0, 32'hff, 32'(x0[7:0]), 1'b0);
    @(posedge pclk);
    align <= 1'b1;
    @(posedge pclk);
    align <= 1'b0;
    acc(1'b0, STATUS_OFFSET, 0, 32'h40, 32'h40, 1'b0);
    x0 = 9'($urandom);
    gear(x0, 9'h0, 9, 1'b1, x0[7:0]);
    acc(1'b0, DATA_OFFSET, 0, 32'hff, 32'(x0[7:0]), 1'b0);
    // fill the word buffer past its depth, then drain it
    for (int i = 0; i < 4; i++) begin
      x0 = 9'($urandom);
      q[i] = x0[7:0];
      gear(x0, 9'h0, 8, 1'b1, x0[7:0]);
    end
    chk(32'(gr), 32'h0);
    gear(9'h0a5, 9'h0, 8, 1'b1, 8'ha5);
    acc(1'b0, STATUS_OFFSET, 0, 32'h7, 32'h6, 1'b0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, DATA_OFFSET, 0, 32'hff, 32'(q[i]), 1'b0);
    end
    acc(1'b0, STATUS_OFFSET, 0, 32'h7, 32'h5, 1'b0);
    acc(1'b1, STATUS_OFFSET, 32'h4, 32'h0, 32'h0, 1'b0);
    acc(1'b0, STATUS_OFFSET, 0, 32'h7, 32'h1, 1'b0);
    end_sim();
  end
endmodule // io_cell_ddr_capture_gearbox_tb

`default_nettype wire
